// *** shared/fll_ref_regs.vh ***
// Register indices, field positions, reset values, masks and codes of the loop reference block
`ifndef FLL_REF_REGS_VH
`define FLL_REF_REGS_VH

// Register indices; the byte address on the bus is four times the index
`define IDX_LOOP_ENABLE      10'h240
`define IDX_FRAC_NUMERATOR   10'h242
`define IDX_REF_FORCE_CTRL   10'h244
`define IDX_FRAC_DENOMINATOR 10'h246
`define IDX_FRAC_MODE        10'h247
`define IDX_LOOP_STATUS      10'h248

// Control register fields, then the loop enable and fraction enable bits
`define POS_BYPASS           15
`define POS_CODE_HI          12
`define POS_CODE_LO          7
`define POS_FORCE            6
`define POS_DIV_HI           4
`define POS_DIV_LO           3
`define POS_SRC_HI           1
`define POS_SRC_LO           0
`define POS_LOOP_ENABLE      0
`define POS_FRAC_ENABLE      0

// Reset values
`define RST_REF_FORCE_CTRL   16'h0c80
`define RST_FORCED_CODE      6'h19
`define RST_FRAC_NUMERATOR   16'h0000
`define RST_FRAC_DENOMINATOR 16'h0000
`define RST_FRAC_MODE        16'h0006

// Implemented bits of the control register
`define MASK_REF_FORCE_CTRL  16'h9fdb

// Reference source codes
`define SRC_MASTER_A         2'h0
`define SRC_MASTER_B         2'h1
`define SRC_AUX_FRAME        2'h2
`define SRC_AUX_BIT          2'h3

// AXI response codes
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// *** core/fll_reference_fraction_cfg.v ***
// Loop reference selection, pre-division, bypass, forced oscillator and fraction registers
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fll_ref_regs.vh"

module fll_reference_fraction_cfg #(
  parameter ADDR_WIDTH = 12                   // Byte address width of the register bus
) (
  input  wire                  clk,           // System clock, 100 MHz
  input  wire                  sys_rst,       // Asynchronous reset, active high
  // AXI4-Lite slave
  input  wire [ADDR_WIDTH-1:0] s_axi_awaddr,  // Write address
  input  wire                  s_axi_awvalid, // Write address valid
  output reg                   s_axi_awready, // Write address ready
  input  wire [31:0]           s_axi_wdata,   // Write data
  input  wire [3:0]            s_axi_wstrb,   // Write byte strobes
  input  wire                  s_axi_wvalid,  // Write data valid
  output reg                   s_axi_wready,  // Write data ready
  output reg  [1:0]            s_axi_bresp,   // Write response
  output reg                   s_axi_bvalid,  // Write response valid
  input  wire                  s_axi_bready,  // Write response ready
  input  wire [ADDR_WIDTH-1:0] s_axi_araddr,  // Read address
  input  wire                  s_axi_arvalid, // Read address valid
  output reg                   s_axi_arready, // Read address ready
  output reg  [31:0]           s_axi_rdata,   // Read data
  output reg  [1:0]            s_axi_rresp,   // Read response
  output reg                   s_axi_rvalid,  // Read data valid
  input  wire                  s_axi_rready,  // Read data ready
  // Reference clock pins, sampled on clk
  input  wire                  masterClockInA, // Master clock input A
  input  wire                  masterClockInB, // Master clock input B
  input  wire                  auxFrameClockIn, // Auxiliary frame clock
  input  wire                  auxBitClockIn, // Auxiliary bit clock
  // Loop core side
  input  wire                  oscClockIn,    // Oscillator clock from the loop core
  input  wire [5:0]            loopCtrlCode,  // Closed-loop oscillator code from the core
  output reg                   refClockDiv,   // Selected, divided reference
  output reg                   loopClockOut,  // Loop output clock
  output reg  [5:0]            oscCode,       // Code applied to the oscillator
  output reg                   loopRun,       // Loop core enable
  output reg                   outputActive,  // Output clock is being delivered
  output reg                   fractionalMode, // 1 fractional, 0 integer
  output reg  [15:0]           ratioNumerator, // Fraction numerator
  output reg  [15:0]           ratioDenominator // Fraction denominator
);

  // Stored registers
  reg  [15:0] refForceCtrl;      // Bypass, forced code, divider, source
  reg  [15:0] fracNumerator;     // Numerator field
  reg  [15:0] fracDenominator;   // Denominator field
  reg  [15:0] fracMode;          // Fraction enable plus reserved bits
  reg         loopEnable;        // Loop enable bit

  // Write channel holding
  reg                  awHeld;   // Write address captured
  reg                  wHeld;    // Write data captured
  reg [ADDR_WIDTH-1:0] awAddr;   // Captured write address
  reg [31:0]           wData;    // Captured write data
  reg [3:0]            wStrb;    // Captured strobes

  // Reference path
  reg        refPrev;            // Previous sample of the selected reference
  reg  [2:0] edgeCount;          // Rising edges of the reference, free count
  reg        refSel;             // Currently selected reference level

  // Decoded fields
  wire       bypassSelect    = refForceCtrl[`POS_BYPASS];
  wire [5:0] forcedCode      = refForceCtrl[`POS_CODE_HI:`POS_CODE_LO];
  wire       forceSelect     = refForceCtrl[`POS_FORCE];
  wire [1:0] dividerSelect   = refForceCtrl[`POS_DIV_HI:`POS_DIV_LO];
  wire [1:0] sourceSelect    = refForceCtrl[`POS_SRC_HI:`POS_SRC_LO];

  // Map a byte address to a register index; misaligned words never match
  function [9:0] regIndex;
    input [ADDR_WIDTH-1:0] addr;
    regIndex = addr[11:2];
  endfunction

  // Known register test, shared by reads and writes
  function isMapped;
    input [ADDR_WIDTH-1:0] addr;
    reg   [9:0]            idx;
    begin
      idx = regIndex(addr);
      isMapped = (addr[1:0] == 2'h0) &&
                 (idx == `IDX_LOOP_ENABLE || idx == `IDX_FRAC_NUMERATOR ||
                  idx == `IDX_REF_FORCE_CTRL || idx == `IDX_FRAC_DENOMINATOR ||
                  idx == `IDX_FRAC_MODE || idx == `IDX_LOOP_STATUS);
    end
  endfunction

  // Byte-lane merge of a 16-bit register with new write data
  function [15:0] mergeLanes;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    mergeLanes = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  wire       doWrite = awHeld && wHeld && !s_axi_bvalid; // Both halves present
  wire [9:0] wIdx    = regIndex(awAddr);                 // Target of the write

  // Write address and data are taken in either order, one write at a time
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= {ADDR_WIDTH{1'b0}};
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !awHeld && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !wHeld && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        // Unknown addresses are ignored and flagged
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(awAddr) && wIdx != `IDX_LOOP_STATUS ? `RESP_OKAY
                                                                      : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register storage
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      refForceCtrl    <= `RST_REF_FORCE_CTRL;
      fracNumerator   <= `RST_FRAC_NUMERATOR;
      fracDenominator <= `RST_FRAC_DENOMINATOR;
      fracMode        <= `RST_FRAC_MODE;
      loopEnable      <= 1'b0;
    end
    else if (doWrite && awAddr[1:0] == 2'h0)
    begin
      case (wIdx)
        `IDX_REF_FORCE_CTRL:
          refForceCtrl <= mergeLanes(refForceCtrl, wData, wStrb) & `MASK_REF_FORCE_CTRL;
        `IDX_FRAC_NUMERATOR:
          fracNumerator <= mergeLanes(fracNumerator, wData, wStrb);
        `IDX_FRAC_DENOMINATOR:
          fracDenominator <= mergeLanes(fracDenominator, wData, wStrb);
        `IDX_FRAC_MODE:
          // Reserved bits 2:1 are stored as written and bits 15:3 held at 0; software keeps bits 2:1 at 1
          fracMode <= {13'h0000, wStrb[0] ? wData[2:0] : fracMode[2:0]};
        `IDX_LOOP_ENABLE:
          if (wStrb[0])
            loopEnable <= wData[`POS_LOOP_ENABLE];
        default:
          loopEnable <= loopEnable;                // Unmapped: nothing changes
      endcase
    end
  end

  // Read channel: one read at a time, answer the cycle after the address
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= isMapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        // Unmapped or misaligned addresses fall to the default and read 0
        case (isMapped(s_axi_araddr) ? regIndex(s_axi_araddr) : 10'h000)
          `IDX_LOOP_ENABLE:      s_axi_rdata <= {31'h0, loopEnable};
          `IDX_FRAC_NUMERATOR:   s_axi_rdata <= {16'h0000, fracNumerator};
          `IDX_REF_FORCE_CTRL:   s_axi_rdata <= {16'h0000, refForceCtrl};
          `IDX_FRAC_DENOMINATOR: s_axi_rdata <= {16'h0000, fracDenominator};
          `IDX_FRAC_MODE:        s_axi_rdata <= {16'h0000, fracMode};
          // Live state: output active, loop running, divided reference, edge count
          `IDX_LOOP_STATUS:
            s_axi_rdata <= {26'h0, edgeCount, refClockDiv, loopRun, outputActive};
          default:               s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Reference source multiplexer
  always @*
  begin
    case (sourceSelect)
      `SRC_MASTER_A:  refSel = masterClockInA;
      `SRC_MASTER_B:  refSel = masterClockInB;
      `SRC_AUX_FRAME: refSel = auxFrameClockIn;
      `SRC_AUX_BIT:   refSel = auxBitClockIn;
      default:        refSel = masterClockInA;
    endcase
  end

  // Pre-divider by 1, 2, 4 or 8; changing source mid-period may stretch one period
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      refPrev     <= 1'b0;
      edgeCount   <= 3'h0;
      refClockDiv <= 1'b0;
    end
    else
    begin
      refPrev <= refSel;
      if (refSel && !refPrev)
        edgeCount <= edgeCount + 3'h1;
      case (dividerSelect)
        2'h0:    refClockDiv <= refSel;
        2'h1:    refClockDiv <= edgeCount[0];
        2'h2:    refClockDiv <= edgeCount[1];
        2'h3:    refClockDiv <= edgeCount[2];
        default: refClockDiv <= refSel;
      endcase
    end
  end

  // Output clock, oscillator code and loop controls
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      loopClockOut     <= 1'b0;
      oscCode          <= 6'h00;
      loopRun          <= 1'b0;
      outputActive     <= 1'b0;
      fractionalMode   <= 1'b0;
      ratioNumerator   <= 16'h0000;
      ratioDenominator <= 16'h0000;
    end
    else
    begin
      // Bypass ignores loop enable so the aux bit clock keeps flowing
      loopClockOut <= bypassSelect ? auxBitClockIn
                                   : (loopEnable & oscClockIn);
      outputActive <= bypassSelect | loopEnable;
      oscCode      <= forceSelect ? forcedCode : loopCtrlCode;
      loopRun      <= loopEnable;
      fractionalMode   <= fracMode[`POS_FRAC_ENABLE];
      ratioNumerator   <= fracNumerator;
      ratioDenominator <= fracDenominator;
    end
  end

endmodule // fll_reference_fraction_cfg

// *** dv/fll_ref_cfg_properties.sv ***
// Bus handshake and clock-path properties of the loop reference block
`timescale 1ns/1ps

module fll_ref_cfg_checker (
  input wire        clk,           // System clock
  input wire        sys_rst,       // Async reset, active high
  input wire        s_axi_awvalid, // Write address valid
  input wire        s_axi_awready, // Write address ready
  input wire        s_axi_wvalid,  // Write data valid
  input wire        s_axi_wready,  // Write data ready
  input wire        s_axi_bvalid,  // Write response valid
  input wire        s_axi_bready,  // Write response ready
  input wire [1:0]  s_axi_bresp,   // Write response
  input wire        s_axi_arvalid, // Read address valid
  input wire        s_axi_arready, // Read address ready
  input wire        s_axi_rvalid,  // Read data valid
  input wire        s_axi_rready,  // Read data ready
  input wire [31:0] s_axi_rdata,   // Read data
  input wire        auxBitClockIn, // Aux bit clock pin
  input wire        loopClockOut,  // Loop output clock
  input wire        outputActive,  // Output being delivered
  input wire        loopRun        // Loop enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Both write halves taken at one edge
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Bypass on, loop off, for three cycles so the path has settled
  sequence bypassOnly;
    (outputActive && !loopRun) [*3];
  endsequence

  chk_bypass_follow: assert property (
    bypassOnly |-> loopClockOut == $past(auxBitClockIn))
    else $error("Output clock not following aux bit clock");
  chk_idle_quiet: assert property (
    !outputActive [*2] |-> !loopClockOut)
    else $error("Output clock toggles while idle");
  chk_run_active: assert property (
    loopRun |-> outputActive)
    else $error("Loop running without active output");
  // Halves are held one edge, the write lands the next, so bvalid shows two edges on
  chk_write_answer: assert property (wrTaken |-> ##2 s_axi_bvalid)
    else $error("Write response late");
  chk_read_answer: assert property (rdTaken |=> s_axi_rvalid)
    else $error("Read data late");
  chk_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early");
  chk_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped early");
  chk_read_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("Upper read half not zero");
  chk_no_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write accepted while response pending");
endmodule // fll_ref_cfg_checker

bind fll_reference_fraction_cfg fll_ref_cfg_checker chk_u (.clk(clk), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .auxBitClockIn(auxBitClockIn), .loopClockOut(loopClockOut),
  .outputActive(outputActive), .loopRun(loopRun));

// *** dv/tb.sv ***
// Self-checking bench for the loop reference block
`timescale 1ns/1ps
`include "fll_ref_regs.vh"

module tb;
  logic        clk = 0;       // System clock
  logic        sys_rst = 1;   // Reset
  logic [11:0] awaddr = 0;    // Write address
  logic [11:0] araddr = 0;    // Read address
  logic [31:0] wdata = 0;     // Write data
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        mcA = 0, mcB = 0, auxFr = 0, auxBit = 0, osc = 0; // Pin levels
  logic [5:0]  ctrlCode = 6'h2a; // Closed-loop code
  logic [2:0]  refPhase = 0;  // Reference period of 8 clocks
  logic [1:0]  refSel = 0;    // Which pin toggles
  logic        prevDiv = 0;   // Divided reference, last edge
  logic        prevLoop = 0;  // Loop output clock, last edge
  logic [31:0] rd;            // Last read data
  logic [1:0]  resp;          // Last response
  wire         awready, wready, bvalid, arready, rvalid, refDiv, loopClk, active, run, frac;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [5:0]  oscCode;
  wire  [15:0] num, den;
  int          errorCnt = 0, nCompared = 0, cycles = 0, rises;
  typedef struct packed { bit wr; logic [11:0] a; logic [31:0] d; logic [31:0] exp; } row_t;
  row_t rows [9] = '{
    '{0, 12'h910, 0, `RST_REF_FORCE_CTRL},
    '{0, 12'h908, 0, `RST_FRAC_NUMERATOR},
    '{0, 12'h918, 0, `RST_FRAC_DENOMINATOR},
    '{0, 12'h91c, 0, `RST_FRAC_MODE},
    '{0, 12'h900, 0, 0},
    '{1, 12'h910, 32'h0000ffff, {16'h0000, `MASK_REF_FORCE_CTRL}},
    '{1, 12'h918, 32'h0000a5c3, 32'h0000a5c3},
    '{1, 12'h908, 32'h00001234, 32'h00001234},
    '{1, 12'h91c, 32'h00000007, 32'h00000007}};

  fll_reference_fraction_cfg dut_u (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .masterClockInA(mcA), .masterClockInB(mcB), .auxFrameClockIn(auxFr),
    .auxBitClockIn(auxBit), .oscClockIn(osc), .loopCtrlCode(ctrlCode),
    .refClockDiv(refDiv), .loopClockOut(loopClk), .oscCode(oscCode), .loopRun(run),
    .outputActive(active), .fractionalMode(frac), .ratioNumerator(num),
    .ratioDenominator(den));

  always #5 clk = ~clk;

  // Only the selected pin toggles, so a wrong source shows as no edges
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    refPhase <= refPhase + 3'h1;
    mcA <= (refSel == `SRC_MASTER_A) & refPhase[2];
    mcB <= (refSel == `SRC_MASTER_B) & refPhase[2];
    auxFr <= (refSel == `SRC_AUX_FRAME) & refPhase[2];
    auxBit <= (refSel == `SRC_AUX_BIT) & refPhase[2];
    osc <= refPhase[1];
    prevDiv <= refDiv;
    prevLoop <= loopClk;
    if (cycles == 20000)
    begin
      errorCnt++;
      conclude();
    end
  end

  task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Edge counts may slip by one at the window ends
  task automatic cmpNear(input int got, input int exp);
    nCompared++;
    if (got < exp - 1 || got > exp + 1)
    begin
      errorCnt++;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  // Both halves offered together, each dropped once taken
  // A nonzero lag keeps bready low that many cycles after both halves are taken
  task automatic axW(input logic [11:0] a, input logic [31:0] d, input int lag = 0);
    bit aw;
    bit w;
    aw = 1;
    w = 1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= (lag == 0);
    while (aw || w)
    begin
      @(posedge clk);
      if (aw && awready === 1'b1) begin aw = 0; awvalid <= 0; end
      if (w && wready === 1'b1) begin w = 0; wvalid <= 0; end
    end
    repeat (lag) @(posedge clk);
    bready <= 1;
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 0;
    repeat (2) @(posedge clk);
  endtask

  // A nonzero lag keeps rready low that many cycles after the address is taken
  task automatic axR(input logic [11:0] a, input int lag = 0);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= (lag == 0);
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    repeat (lag) @(posedge clk);
    rready <= 1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 0;
  endtask

  // Rising edges over n cycles of the loop clock, or else of the divided reference
  task automatic countRises(input bit loopSide, input int n);
    rises = 0;
    repeat (n)
    begin
      @(posedge clk);
      if (loopSide ? (loopClk && !prevLoop) : (refDiv && !prevDiv))
        rises++;
    end
  endtask

  task conclude;
    $display("Compared %0d, errors %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        axW(rows[i].a, rows[i].d);
      axR(rows[i].a);
      cmpVal(rd, rows[i].exp);
    end
    cmpVal(den, 32'h0000a5c3);
    cmpVal(num, 32'h00001234);
    cmpVal(frac, 1);
    cmpVal(oscCode, 6'h3f);
    cmpVal({active, run}, 2'b10);
    axW(12'h910, `RST_REF_FORCE_CTRL);
    cmpVal(oscCode, ctrlCode);
    axW(12'h910, 32'h00000040);
    cmpVal(oscCode, 6'h00);
    // Every source with a distinct divider; 256 clocks hold 32 reference periods
    // The 12.5 MHz reference is already low enough, so larger dividers only save power
    for (int s = 0; s < 4; s++)
    begin
      refSel <= s[1:0];
      axW(12'h910, 32'h00000c80 | (s << 3) | s);
      repeat (16) @(posedge clk);
      countRises(0, 256);
      cmpNear(rises, 32 >> s);
    end
    // Bypass with the loop off: the aux bit clock, period 8, reaches the output
    axW(12'h910, 32'h00008c80);
    countRises(1, 64);
    cmpNear(rises, 8);
    cmpVal({active, run}, 2'b10);
    axW(12'h900, 32'h00000001);
    cmpVal({active, run}, 2'b11);
    // Bypass off: the oscillator clock, period 4, passes while the loop is enabled
    axW(12'h910, 32'h00000c80);
    countRises(1, 64);
    cmpNear(rises, 16);
    // Late ready on both answer channels; response and data must stand meanwhile
    axW(12'h918, 32'h00005a3c, 3);
    cmpVal(resp, `RESP_OKAY);
    axR(12'h918, 3);
    cmpVal(rd, 32'h00005a3c);
    cmpVal(den, 32'h00005a3c);
    axR(12'ha00);
    cmpVal(rd, 32'h0);
    cmpVal(resp, `RESP_SLVERR);
    axW(12'h920, 32'h00000001);
    cmpVal(resp, `RESP_SLVERR);
    // Reset again mid-run and look for defaults
    sys_rst <= 1;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    cmpVal({active, run, frac}, 3'b000);
    axR(12'h910);
    cmpVal(rd, `RST_REF_FORCE_CTRL);
    conclude();
  end
endmodule // tb
